//--- lbr_pkg.sv
// Package: register map, field layout and carriers of the ballast register bank
// How it works
// RULE1: Locations 0x01 and 0x02 are byte-wide read/write dimming duty registers, one per string, zero after reset.
// RULE2: Locations 0x03 and 0x04 hold a 7-bit string current setting in bits 6..0 and a fuse lock flag in bit 7.
// RULE3: The lock flags in bit 7 of 0x03 and 0x04 are read-only, so only bits 6..0 take writes.
// RULE4: Locations 0x05 and 0x06 are full byte read/write short thresholds for string one and string two.
// RULE5: Location 0x07 holds booster disable in bit 7, oscillator frequency in bits 6..4 and output range in bits 3..0.
// RULE6: Location 0x08 holds the first off-time range up top, derating disable in bit 3 and dimming factor in bits 2..0.
// RULE7: Writes to the test-only fields of 0x09, 0x0A, 0x0B and 0x0F land only while the test mode pin is high.
// RULE8: Location 0x09 holds fuse start in bit 7, a 2-bit command in 6..5, reserved bit 4 and a 4-bit address; 0x0A holds fuse data.
// RULE9: Location 0x0B holds reserved bit 7, second off-time range in bits 6..3 and converter channel select in bits 2..0.
// RULE10: Location 0x0F takes a test command on write in test mode and returns the revision code on read.
// RULE11: Status locations 0x0C to 0x0E are read-only and writes to them change nothing. The code clears the frame error flag on a write to 0x0D.
// RULE12: A serial transfer whose length is not a multiple of sixteen bits sets the frame error flag in status two.
// RULE13: Location 0x00 is a no-operation address: writes do nothing and reads return zero.
package lbr_pkg;
   localparam logic [3:0] ADDR_NO_OPERATION = 4'h0;
   localparam logic [3:0] ADDR_DIM_DUTY_ONE = 4'h1;
   localparam logic [3:0] ADDR_DIM_DUTY_TWO = 4'h2;
   localparam logic [3:0] ADDR_CURRENT_ONE = 4'h3;
   localparam logic [3:0] ADDR_CURRENT_TWO = 4'h4;
   localparam logic [3:0] ADDR_SHORT_ONE = 4'h5;
   localparam logic [3:0] ADDR_SHORT_TWO = 4'h6;
   localparam logic [3:0] ADDR_BOOSTER_CONFIG = 4'h7;
   localparam logic [3:0] ADDR_OFFTIME_DIMMING = 4'h8;
   localparam logic [3:0] ADDR_FUSE_CONTROL = 4'h9;
   localparam logic [3:0] ADDR_FUSE_DATA = 4'ha;
   localparam logic [3:0] ADDR_CONVERTER_SELECT = 4'hb;
   localparam logic [3:0] ADDR_DIAG_ONE = 4'hc;
   localparam logic [3:0] ADDR_DIAG_TWO = 4'hd;
   localparam logic [3:0] ADDR_CONVERTER_RESULT = 4'he;
   localparam logic [3:0] ADDR_TEST_REVISION = 4'hf;

   localparam logic [7:0] REG_RESET = 8'h00;
   // Writable masks per location
   localparam logic [7:0] MASK_CURRENT = 8'h7f;
   localparam logic [7:0] MASK_FUSE_CONTROL = 8'hef;
   localparam logic [7:0] MASK_SEL_FREE = 8'h78;
   localparam logic [7:0] MASK_SEL_TEST = 8'h07;
   localparam int LOCK_BIT = 7;
   localparam int FRAME_BITS = 16;
   localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
   // Pin vector positions in the synchroniser
   localparam int PIN_CSB = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_SDI = 2;
   localparam int PIN_TEST = 3;
   localparam int PIN_COUNT = 4;
   localparam logic [PIN_COUNT-1:0] PIN_IDLE = 4'h1;

   typedef struct packed {
      logic [7:0] dimDutyOne;
      logic [7:0] dimDutyTwo;
      logic [6:0] currentOne;
      logic [6:0] currentTwo;
      logic [7:0] shortThresholdOne;
      logic [7:0] shortThresholdTwo;
      logic [7:0] boosterConfig;
      logic [7:0] offtimeDimmingConfig;
      logic [7:0] fuseMemoryControl;
      logic [7:0] fuseMemoryData;
      logic [7:0] converterSelectControl;
      logic [7:0] testCommand;
   } lbr_ctrl_type;

   typedef struct packed {
      logic boosterUndervoltage;
      logic dutyCycleLimitReached;
      logic powerDeratingActive;
      logic stringOneOpen;
      logic stringOneShort;
      logic stringOneSingleShort;
      logic stringOneOvercurrent;
      logic thermalWarning;
      logic thermalShutdown;
      logic stringTwoOpen;
      logic stringTwoShort;
      logic stringTwoSingleShort;
      logic stringTwoOvercurrent;
      logic fuseLockInternal;
      logic fuseLockExternal;
      logic [7:0] converterResult;
   } lbr_status_type;
endpackage

//--- lbr_register_bank.sv
// Module: serial-reached register bank of the two-string ballast
module lbr_register_bank #(
   parameter logic [7:0] SILICON_REVISION_CODE = 8'h01 // Arbitrary value
) (
   input wire logic clk, // 50 MHz clock
   input wire logic rst_b, // Synchronous reset, low
   input wire logic ce, // Clock enable, freezes all state
   input wire logic csB, // Serial chip select pin, low active
   input wire logic sclk, // Serial clock pin
   input wire logic sdi, // Serial data in pin
   input wire logic test_mode_pin, // Test mode pin
   input wire lbr_pkg::lbr_status_type status, // Diagnostics, same clock
   output logic sdo, // Serial data out pin
   output logic sdoOe, // Serial data out enable
   output lbr_pkg::lbr_ctrl_type ctrl, // Control settings
   output logic testCommandStrobe // One pulse per test command
);
   import lbr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [PIN_COUNT-1:0] pinS1_ff;
   logic [PIN_COUNT-1:0] pinS2_ff;
   logic [PIN_COUNT-1:0] pinS3_ff;
   logic [PIN_COUNT-1:0] pinQ_ff;

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               pinS1_ff[gi] <= PIN_IDLE[gi];
               pinS2_ff[gi] <= PIN_IDLE[gi];
               pinS3_ff[gi] <= PIN_IDLE[gi];
               pinQ_ff[gi] <= PIN_IDLE[gi];
            end else if (ce) begin
               pinS1_ff[gi] <= gi == PIN_CSB ? csB :
                               gi == PIN_SCLK ? sclk :
                               gi == PIN_SDI ? sdi : test_mode_pin;
               pinS2_ff[gi] <= pinS1_ff[gi];
               pinS3_ff[gi] <= pinS2_ff[gi];
               // Change counts only once two stages agree
               if (pinS2_ff[gi] == pinS3_ff[gi]) begin
                  pinQ_ff[gi] <= pinS3_ff[gi];
               end
            end
         end
      end
   endgenerate

   logic [PIN_COUNT-1:0] pinNext;
   logic csbFall;
   logic csbRise;
   logic sclkRise;
   logic sclkFall;
   logic inFrame;
   logic testMode;

   always_comb begin
      pinNext = pinQ_ff;
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (pinS2_ff[i] == pinS3_ff[i]) begin
            pinNext[i] = pinS3_ff[i];
         end
      end
   end

   assign csbFall = pinQ_ff[PIN_CSB] && !pinNext[PIN_CSB];
   assign csbRise = !pinQ_ff[PIN_CSB] && pinNext[PIN_CSB];
   assign inFrame = !pinQ_ff[PIN_CSB];
   assign sclkRise = inFrame && !pinQ_ff[PIN_SCLK] && pinNext[PIN_SCLK];
   assign sclkFall = inFrame && pinQ_ff[PIN_SCLK] && !pinNext[PIN_SCLK];
   assign testMode = pinQ_ff[PIN_TEST];

   ////////////////////////////////////////////////////////////////////////
   // Frame shifter

   logic [FRAME_BITS-1:0] shiftIn_ff;
   logic [FRAME_BITS-1:0] shiftOut_ff;
   logic [FRAME_BITS-1:0] respWord_ff;
   logic [3:0] bitCount_ff;
   logic anyBit_ff;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shiftIn_ff <= '0;
         bitCount_ff <= BIT_COUNT_ZERO;
         anyBit_ff <= 1'b0;
      end else if (ce) begin
         if (csbFall) begin
            bitCount_ff <= BIT_COUNT_ZERO;
            anyBit_ff <= 1'b0;
         end else if (sclkRise) begin
            // Last sixteen bits kept, so daisy chains work
            shiftIn_ff <= {shiftIn_ff[FRAME_BITS-2:0], pinQ_ff[PIN_SDI]};
            bitCount_ff <= bitCount_ff + 4'h1;
            anyBit_ff <= 1'b1;
         end
      end
   end

   // Response is latched at select fall and moved out on falling clock
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shiftOut_ff <= '0;
      end else if (ce) begin
         if (csbFall) begin
            shiftOut_ff <= respWord_ff;
         end else if (sclkFall) begin
            shiftOut_ff <= {shiftOut_ff[FRAME_BITS-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sdo <= 1'b0;
         sdoOe <= 1'b0;
      end else if (ce) begin
         sdoOe <= !pinNext[PIN_CSB];
         sdo <= csbFall ? respWord_ff[FRAME_BITS-1] :
                sclkFall ? shiftOut_ff[FRAME_BITS-2] :
                shiftOut_ff[FRAME_BITS-1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command decode at select rise

   logic frameGood;
   logic frameBad;
   logic [3:0] wrAddr;
   logic [3:0] rdAddr;
   logic [7:0] wrData;
   logic doWrite;

   assign frameGood = csbRise && anyBit_ff && bitCount_ff == BIT_COUNT_ZERO;
   assign frameBad = csbRise && bitCount_ff != BIT_COUNT_ZERO; // [RULE12]
   assign wrAddr = shiftIn_ff[15:12];
   assign rdAddr = shiftIn_ff[11:8];
   assign wrData = shiftIn_ff[7:0];
   assign doWrite = frameGood;

   function automatic logic wrHit(input logic [3:0] a, input logic [3:0] w);
      wrHit = doWrite && wrAddr == a && a == w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   logic [7:0] dimOne_ff;
   logic [7:0] dimTwo_ff;
   logic [6:0] curOne_ff;
   logic [6:0] curTwo_ff;
   logic [7:0] shortOne_ff;
   logic [7:0] shortTwo_ff;
   logic [7:0] booster_ff;
   logic [7:0] offDim_ff;
   logic [7:0] fuseCtrl_ff;
   logic [7:0] fuseData_ff;
   logic [7:0] convSel_ff;
   logic [7:0] testCmd_ff;
   logic testStrobe_ff;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dimOne_ff <= REG_RESET;
         dimTwo_ff <= REG_RESET;
      end else if (ce) begin
         if (wrHit(ADDR_DIM_DUTY_ONE, wrAddr)) dimOne_ff <= wrData; // [RULE1]
         if (wrHit(ADDR_DIM_DUTY_TWO, wrAddr)) dimTwo_ff <= wrData; // [RULE1]
      end
   end

   // Lock flags live outside, only the setting takes writes
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         curOne_ff <= REG_RESET[6:0];
         curTwo_ff <= REG_RESET[6:0];
      end else if (ce) begin
         if (wrHit(ADDR_CURRENT_ONE, wrAddr)) begin
            curOne_ff <= wrData[6:0]; // [RULE2] [RULE3]
         end
         if (wrHit(ADDR_CURRENT_TWO, wrAddr)) begin
            curTwo_ff <= wrData[6:0]; // [RULE2] [RULE3]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shortOne_ff <= REG_RESET;
         shortTwo_ff <= REG_RESET;
      end else if (ce) begin
         if (wrHit(ADDR_SHORT_ONE, wrAddr)) shortOne_ff <= wrData; // [RULE4]
         if (wrHit(ADDR_SHORT_TWO, wrAddr)) shortTwo_ff <= wrData; // [RULE4]
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         booster_ff <= REG_RESET;
         offDim_ff <= REG_RESET;
      end else if (ce) begin
         if (wrHit(ADDR_BOOSTER_CONFIG, wrAddr)) begin
            booster_ff <= wrData; // [RULE5]
         end
         if (wrHit(ADDR_OFFTIME_DIMMING, wrAddr)) begin
            offDim_ff <= wrData; // [RULE6]
         end
      end
   end

   // Fuse controls only move in test mode; reserved bits stay zero
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         fuseCtrl_ff <= REG_RESET;
         fuseData_ff <= REG_RESET;
      end else if (ce && testMode) begin // [RULE7]
         if (wrHit(ADDR_FUSE_CONTROL, wrAddr)) begin
            fuseCtrl_ff <= wrData & MASK_FUSE_CONTROL; // [RULE8]
         end
         if (wrHit(ADDR_FUSE_DATA, wrAddr)) begin
            fuseData_ff <= wrData; // [RULE8]
         end
      end
   end

   // Off-time range always writable, channel select test-only
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         convSel_ff <= REG_RESET;
      end else if (ce && wrHit(ADDR_CONVERTER_SELECT, wrAddr)) begin
         convSel_ff <= (wrData & MASK_SEL_FREE) |
                       ((testMode ? wrData : convSel_ff) & MASK_SEL_TEST);
         // [RULE7] [RULE9]
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         testCmd_ff <= REG_RESET;
         testStrobe_ff <= 1'b0;
      end else if (ce) begin
         testStrobe_ff <= 1'b0;
         if (testMode && wrHit(ADDR_TEST_REVISION, wrAddr)) begin // [RULE10]
            testCmd_ff <= wrData;
            testStrobe_ff <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status, read-only; a write address of 0x0D only clears the frame error flag [RULE11] [RULE13]

   logic frameErr_ff;
   logic [7:0] diagOne;
   logic [7:0] diagTwo;
   logic readsDiagTwo;

   // Sticky until reported; a new error beats the clear
   assign readsDiagTwo = frameGood &&
      (rdAddr == ADDR_DIAG_TWO || wrAddr == ADDR_DIAG_TWO);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         frameErr_ff <= 1'b0;
      end else if (ce) begin
         if (frameBad) begin
            frameErr_ff <= 1'b1; // [RULE12]
         end else if (readsDiagTwo) begin
            frameErr_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      diagOne[6:0] = {status.boosterUndervoltage,
                      status.dutyCycleLimitReached,
                      status.powerDeratingActive,
                      status.stringOneOpen, status.stringOneShort,
                      status.stringOneSingleShort,
                      status.stringOneOvercurrent};
      diagTwo[6:0] = {status.thermalWarning, status.thermalShutdown,
                      frameErr_ff,
                      status.stringTwoOpen, status.stringTwoShort,
                      status.stringTwoSingleShort,
                      status.stringTwoOvercurrent};
      // Odd parity over the byte
      diagOne[7] = ~^diagOne[6:0];
      diagTwo[7] = ~^diagTwo[6:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux and response word

   function automatic logic [7:0] readReg(input logic [3:0] a);
      unique case (a)
         ADDR_NO_OPERATION: readReg = REG_RESET; // [RULE13]
         ADDR_DIM_DUTY_ONE: readReg = dimOne_ff;
         ADDR_DIM_DUTY_TWO: readReg = dimTwo_ff;
         ADDR_CURRENT_ONE: readReg = {status.fuseLockInternal, curOne_ff};
         ADDR_CURRENT_TWO: readReg = {status.fuseLockExternal, curTwo_ff};
         ADDR_SHORT_ONE: readReg = shortOne_ff;
         ADDR_SHORT_TWO: readReg = shortTwo_ff;
         ADDR_BOOSTER_CONFIG: readReg = booster_ff;
         ADDR_OFFTIME_DIMMING: readReg = offDim_ff;
         ADDR_FUSE_CONTROL: readReg = fuseCtrl_ff;
         ADDR_FUSE_DATA: readReg = fuseData_ff;
         ADDR_CONVERTER_SELECT: readReg = convSel_ff;
         ADDR_DIAG_ONE: readReg = diagOne;
         ADDR_DIAG_TWO: readReg = diagTwo;
         ADDR_CONVERTER_RESULT: readReg = status.converterResult;
         ADDR_TEST_REVISION: readReg = SILICON_REVISION_CODE; // [RULE10]
      endcase
   endfunction

   // Values before this frame's write are reported
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         respWord_ff <= '0;
      end else if (ce && frameGood) begin
         respWord_ff <= {readReg(wrAddr), readReg(rdAddr)};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl <= '0;
         testCommandStrobe <= 1'b0;
      end else if (ce) begin
         ctrl.dimDutyOne <= dimOne_ff;
         ctrl.dimDutyTwo <= dimTwo_ff;
         ctrl.currentOne <= curOne_ff;
         ctrl.currentTwo <= curTwo_ff;
         ctrl.shortThresholdOne <= shortOne_ff;
         ctrl.shortThresholdTwo <= shortTwo_ff;
         ctrl.boosterConfig <= booster_ff;
         ctrl.offtimeDimmingConfig <= offDim_ff;
         ctrl.fuseMemoryControl <= fuseCtrl_ff;
         ctrl.fuseMemoryData <= fuseData_ff;
         ctrl.converterSelectControl <= convSel_ff;
         ctrl.testCommand <= testCmd_ff;
         testCommandStrobe <= testStrobe_ff;
      end
   end
endmodule // lbr_register_bank

//--- lbr_register_bank_asserts.sv
// Checker: port-level properties of the ballast register bank
module lbr_register_bank_asserts (
   input wire logic clk, // Clock
   input wire logic rst_b, // Reset, low
   input wire logic ce, // Clock enable
   input wire logic csB, // Select pin
   input wire logic sclk, // Serial clock pin
   input wire logic sdi, // Serial data in
   input wire logic test_mode_pin, // Test pin
   input wire lbr_pkg::lbr_status_type status, // Diagnostics
   input wire logic sdo, // Serial data out
   input wire logic sdoOe, // Data out enable
   input wire lbr_pkg::lbr_ctrl_type ctrl, // Control settings
   input wire logic testCommandStrobe // Test command pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   import lbr_pkg::*;
   logic [3:0] sinceRise_ff;
   logic [15:0] testHist_ff;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   // Cycles since select went high; writes may only land shortly after
   always_ff @(posedge clk) begin
      if (!rst_b || !csB) begin
         sinceRise_ff <= 4'h0;
      end else if (ce && sinceRise_ff != 4'hf) begin
         sinceRise_ff <= sinceRise_ff + 4'h1;
      end
   end
   // Wide window: the pin passes a synchroniser before use
   always_ff @(posedge clk) begin
      testHist_ff <= {testHist_ff[14:0], test_mode_pin};
   end
   ////////////////////////////////////////////////////////////////////////
   reset_clears_ctrl_a: assert property (
      $rose(rst_b) |-> ctrl == '0 && !sdoOe && !testCommandStrobe)
      else $error("outputs not cleared by reset");
   write_after_frame_a: assert property (
      $changed(ctrl) && $past(rst_b) && $past(ce)
      |-> sinceRise_ff inside {[3:12]})
      else $error("control changed outside a frame decode");
   fuse_reserved_zero_a: assert property (
      ctrl.fuseMemoryControl[4] == 1'b0)
      else $error("reserved fuse control bit set");
   adc_reserved_zero_a: assert property (
      ctrl.converterSelectControl[7] == 1'b0)
      else $error("reserved converter select bit set");
   test_fields_guard_a: assert property (
      ($changed(ctrl.fuseMemoryControl) || $changed(ctrl.fuseMemoryData)
      || $changed(ctrl.converterSelectControl[2:0])
      || $changed(ctrl.testCommand)) && $past(rst_b)
      |-> testHist_ff != 16'h0000)
      else $error("test field written outside test mode");
   strobe_single_a: assert property (
      testCommandStrobe |=> !testCommandStrobe)
      else $error("test command pulse too long");
   strobe_in_test_a: assert property (
      testCommandStrobe |-> testHist_ff != 16'h0000
      && sinceRise_ff inside {[2:12]})
      else $error("test command pulse without test write");
   oe_idle_low_a: assert property (
      csB [*6] |-> !sdoOe)
      else $error("data out enabled while deselected");
   oe_in_frame_a: assert property (
      !csB [*6] |-> sdoOe)
      else $error("data out not enabled inside a frame");
   sdo_hold_high_a: assert property (
      sclk [*4] |=> $stable(sdo))
      else $error("data out changed while serial clock high");
   freeze_on_ce_a: assert property (
      !ce |=> $stable(ctrl))
      else $error("control changed with clock enable low");
   cover property (testCommandStrobe);
   cover property ($changed(ctrl.fuseMemoryData));
   cover property ($changed(ctrl.dimDutyOne));
endmodule // lbr_register_bank_asserts

bind lbr_register_bank lbr_register_bank_asserts lbr_register_bank_asserts_i (
   .clk(clk), .rst_b(rst_b), .ce(ce), .csB(csB), .sclk(sclk), .sdi(sdi),
   .test_mode_pin(test_mode_pin), .status(status), .sdo(sdo),
   .sdoOe(sdoOe), .ctrl(ctrl), .testCommandStrobe(testCommandStrobe));

//--- lbr_register_bank_test.sv
// Testbench: register bank against a reference model of the map
module lbr_register_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   import lbr_pkg::*;
   localparam logic [7:0] REV = 8'h5a; // Arbitrary revision value
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic testMode = 1'b0;
   logic csB, sclk, sdi, sdo, sdoOe, testCommandStrobe;
   lbr_status_type status = '0;
   lbr_ctrl_type ctrl;
   logic [7:0] m [16];
   logic [15:0] pend, resp;
   logic pendOk = 1'b0;
   logic frameErr = 1'b0;
   int error_cnt = 0;
   int n_checks = 0;
   int strobes = 0;
   int expStrobes = 0;
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (testCommandStrobe === 1'b1) strobes <= strobes + 1;
   end
   lbr_register_bank #(.SILICON_REVISION_CODE(REV)) lbr_register_bank_i (
      .clk(clk), .rst_b(rst_b), .ce(ce), .csB(csB), .sclk(sclk), .sdi(sdi),
      .test_mode_pin(testMode), .status(status), .sdo(sdo),
      .sdoOe(sdoOe), .ctrl(ctrl), .testCommandStrobe(testCommandStrobe));
   lbr_spi_master lbr_spi_master_i (
      .clk(clk), .sdo(sdo), .csB(csB), .sclk(sclk), .sdi(sdi));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [95:0] seen,
                      input logic [95:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [7:0] rd(input int a);
      logic [6:0] dd;
      dd = {status[15:14], frameErr, status[13:10]};
      case (a)
         0: return 8'h00;
         3: return {status.fuseLockInternal, m[3][6:0]};
         4: return {status.fuseLockExternal, m[4][6:0]};
         12: return {~^status[22:16], status[22:16]};
         13: return {~^dd, dd};
         14: return status[7:0];
         15: return REV;
         default: return m[a];
      endcase
   endfunction
   task automatic wr(input int a, input logic [7:0] d);
      case (a)
         1, 2, 5, 6, 7, 8: m[a] = d;
         3, 4: m[a] = {1'b0, d[6:0]};
         9: if (testMode) m[a] = d & 8'hef;
         10: if (testMode) m[a] = d;
         11: m[a] = {1'b0, d[6:3], testMode ? d[2:0] : m[a][2:0]};
         15: if (testMode) begin
            m[a] = d;
            expStrobes++;
         end
         default: ;
      endcase
   endtask
   // One frame through the partner, then model update and compares
   task automatic op(input int n, input logic [31:0] w);
      logic [93:0] e;
      logic [15:0] pe;
      lbr_spi_master_i.frame(n, w, resp);
      // A short frame only clocks out the leading bits of the response
      pe = n < 16 ? pend >> (16 - n) : pend;
      if (pendOk) chk("response", resp, pe);
      pendOk = n % 16 == 0 && n > 0;
      if (n % 16 != 0) frameErr = 1'b1;
      else if (n > 0) begin
         pend = {rd(w[15:12]), rd(w[11:8])};
         if (w[15:12] == 4'hd || w[11:8] == 4'hd) frameErr = 1'b0;
         wr(w[15:12], w[7:0]);
      end
      repeat (12) @(posedge clk);
      e = {m[1], m[2], m[3][6:0], m[4][6:0], m[5], m[6], m[7], m[8], m[9],
           m[10], m[11], m[15]};
      chk("ctrl", ctrl, e);
      chk("strobes", strobes, expStrobes);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'heefb));
      foreach (m[i]) m[i] = 8'h00;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      for (int a = 0; a < 17; a++) op(16, {16'h0, 4'h0, a[3:0], 8'h00});
      $display("reset values done");
      for (int t = 0; t < 2; t++) begin
         testMode <= t[0];
         for (int a = 0; a < 17; a++) op(16, {16'h0, a[3:0], a[3:0], 8'hff});
      end
      $display("write sweep done");
      op(15, 32'h1234);
      op(0, 32'h0);
      op(17, 32'h1a5a5);
      op(32, 32'hbeef0d00);
      op(16, 32'h00d0);
      $display("framing done");
      for (int i = 0; i < 80; i++) begin
         testMode <= 1'($urandom_range(1));
         status <= 23'($urandom);
         op($urandom_range(7) == 0 ? 17 : ($urandom_range(4) == 0 ? 32 : 16),
            $urandom);
      end
      $display("random frames done");
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      foreach (m[i]) m[i] = 8'h00;
      {pendOk, frameErr} = 2'b00;
      repeat (4) @(posedge clk);
      op(16, 32'h0d00);
      op(16, 32'h0000);
      $display("freeze and reset done");
      complete_run();
   end
   // About 35k clk expected; this leaves ample margin
   initial begin
      #1500us;
      error_cnt++;
      complete_run();
   end
endmodule // lbr_register_bank_test

//--- lbr_spi_master.sv
// Partner: behavioural serial master facing the register bank
module lbr_spi_master (
   input wire logic clk, // Clock
   input wire logic sdo, // Data from the bank
   output logic csB, // Select, low active
   output logic sclk, // Serial clock, idles low
   output logic sdi // Data to the bank
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      csB = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // Six clk per phase keeps a margin over the synchroniser delay
   task automatic frame(input int n, input logic [31:0] w,
                        output logic [15:0] r);
      r = '0;
      @(posedge clk) csB <= 1'b0;
      repeat (6) @(posedge clk);
      for (int i = n - 1; i >= 0; i--) begin
         sdi <= w[i];
         repeat (6) @(posedge clk);
         // Response sits in the first sixteen bits; later ones are fill
         if (i >= n - 16) r = {r[14:0], sdo};
         sclk <= 1'b1;
         repeat (6) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (6) @(posedge clk);
      csB <= 1'b1;
      sdi <= ~sdi; // Stale data must not look valid
      repeat (6) @(posedge clk);
   endtask
endmodule // lbr_spi_master
